/* rtl/dcsf_pkg.sv */
/*
 * Shared constants and types of the 9-bit first-in first-out buffer core.
 * Assumes one system clock and an APB master that uses byte addresses.
 */
`default_nettype none

package dcsf_pkg;

    // Data path and depth
    localparam int DATA_W = 9;
    localparam int DEPTH_DEF = 64;
    localparam int OFS_W = 14;

    // APB register map, byte addresses
    localparam int APB_AW = 8;
    localparam logic [APB_AW-1:0] REG_STATUS = 8'h00;
    localparam logic [APB_AW-1:0] REG_EMPTY_OFS = 8'h04;
    localparam logic [APB_AW-1:0] REG_FULL_OFS = 8'h08;
    localparam logic [APB_AW-1:0] REG_WR_LEVEL = 8'h0C;
    localparam logic [APB_AW-1:0] REG_RD_LEVEL = 8'h10;
    localparam logic [APB_AW-1:0] REG_CTRL = 8'h14;

    // Status register field positions
    localparam int ST_FLAGS_LSB = 0;
    localparam int ST_FLAGS_W = 5;
    localparam int ST_OVERRUN_BIT = 8;
    localparam int ST_UNDERRUN_BIT = 9;

    // Control register field positions
    localparam int CTRL_FLUSH_BIT = 0;

    // Reset values
    localparam logic [OFS_W-1:0] EMPTY_OFS_RST = 14'h0007;
    localparam logic [OFS_W-1:0] FULL_OFS_RST = 14'h0007;
    localparam logic [4:0] FLAGS_RST = 5'h03;
    localparam logic [31:0] PRDATA_RST = 32'h0000_0000;

    // Flag group, all flags active low except the mode bit
    typedef struct packed {
        logic dualWr;
        logic almostEmptyN;
        logic emptyN;
        logic almostFullN;
        logic fullN;
    } dcsf_flags_t;

    // APB request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [APB_AW-1:0] paddr;
        logic [31:0] pwdata;
    } dcsf_apb_req_t;

endpackage

`default_nettype wire

/* rtl/dcsf_core.sv */
/*
 * First-in first-out buffer core with write port, read port, four status
 * flags, pin-selected write configuration and an APB register slave.
 * Assumes write and read ports share core_clk and that all inputs are
 * synchronous to it; the tri-state driver sits outside, fed by rdDataOe.
 */
`default_nettype none

// Contract
// (RL1) Reset returns both read and write pointers to the first location.
// (RL2) Outside logic resets the buffer after power-up before writing.
// (RL3) Reset drives full and almost-full high, empty and almost-empty low.
// (RL4) Reset zeroes the output register and loads default flag offsets.
// (RL5) Input and output data paths are nine bits wide.
// (RL6) In programmable-flag configuration the first write enable alone gates writes.
// (RL7) Words are stored sequentially, independent of concurrent reads.
// (RL8) With the write enable high nothing new is written.
// (RL9) Dual-write-enable configuration gates writes with two enables.
// (RL10) Full buffer drives full flag low and ignores write enables.
// (RL11) A completed read on a full buffer releases the full flag.
// (RL12) Full and almost-full flags change only on write-clock edges.
// (RL13) Works with coincident or asynchronous read and write clocks; here both sides run on core_clk only.
// (RL14) Both read enables low loads the next word into the output register.
// (RL15) Either read enable high holds the output register.
// (RL16) Empty buffer drives empty flag low and ignores read enables.
// (RL17) A write into an empty buffer raises the empty flag.
// (RL18) Empty and almost-empty flags change only on read-clock edges.
// (RL19) Second enable level during reset selects dual-enable or programmable-flag mode.
// (RL20) Output enable high floats the data bus, low drives the output register.
// (RL21) Default almost-full flag goes low seven words short of full.
// (RL22) Default almost-empty flag stays low until more than seven words are held.
// (RL23) Depth is a parameter from 64 to 8192 with derived pointer widths.
// (RL24) Pointers cross between sides Gray-coded through synchronisers.
module dcsf_core
    import dcsf_pkg::*;
#(
    parameter int DEPTH = DEPTH_DEF,
    parameter int DW = DATA_W
) (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // Device control pins
    input wire logic resetNIn,
    input wire logic wrEnFirstN,
    input wire logic wrEnSecondOrLoad,
    input wire logic rdEnAN,
    input wire logic rdEnBN,
    input wire logic outEnN,
    // Data
    input wire logic [DW-1:0] wrDataIn,
    output logic [DW-1:0] rdDataOut,
    output logic rdDataOe,
    // Flags
    output logic fullFlagN,
    output logic almostFullFlagN,
    output logic emptyFlagN,
    output logic almostEmptyFlagN,
    // APB slave
    input wire dcsf_apb_req_t apbReq,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    localparam int AW = $clog2(DEPTH); // RL23
    localparam logic [AW:0] DEPTH_CNT = (AW + 1)'(DEPTH);

    typedef logic [AW:0] dcsf_ptr_t;

    function automatic dcsf_ptr_t bin2gray(input dcsf_ptr_t b);
        return b ^ (b >> 1);
    endfunction

    function automatic dcsf_ptr_t gray2bin(input dcsf_ptr_t g);
        dcsf_ptr_t b;
        b[AW] = g[AW];
        for (int i = AW - 1; i >= 0; i--) begin
            b[i] = b[i + 1] ^ g[i];
        end
        return b;
    endfunction

    // Level plus offset reaches the depth
    function automatic logic reachesFull(input dcsf_ptr_t lvl, input logic [OFS_W-1:0] ofs);
        logic [OFS_W:0] sum;
        sum = (OFS_W + 1)'(lvl) + (OFS_W + 1)'(ofs);
        return sum >= (OFS_W + 1)'(DEPTH);
    endfunction

    function automatic logic [31:0] widen(input dcsf_ptr_t lvl);
        return 32'(lvl);
    endfunction

    // Storage and pointers
    logic [DW-1:0] mem [DEPTH];
    dcsf_ptr_t wrPtr;
    dcsf_ptr_t wrGray;
    dcsf_ptr_t rdPtr;
    dcsf_ptr_t rdGray;
    dcsf_ptr_t rdGraySync1;
    dcsf_ptr_t rdGraySync2;
    dcsf_ptr_t wrGraySync1;
    dcsf_ptr_t wrGraySync2;
    dcsf_ptr_t next_wrPtr;
    dcsf_ptr_t next_rdPtr;
    dcsf_ptr_t wrLevel;
    dcsf_ptr_t rdLevel;

    // Control and configuration
    logic devRst;
    logic flushReq;
    logic fifoRst;
    logic dualWr;
    logic wrGate;
    logic wrAccept;
    logic rdGate;
    logic rdAccept;
    logic overrun;
    logic underrun;
    logic [OFS_W-1:0] emptyOfs;
    logic [OFS_W-1:0] fullOfs;
    dcsf_flags_t flags;

    // APB decode
    logic apbSetup;
    logic apbAccess;
    logic apbWrite;
    logic errReg;
    logic addrHit;
    logic [31:0] rdMux;

    // Pin reset, system reset, flush
    assign devRst = rst | ~resetNIn;
    assign fifoRst = devRst | flushReq;

    // Configuration caught while reset is held
    always_ff @(posedge core_clk) begin
        if (ce && devRst) begin
            dualWr <= wrEnSecondOrLoad; // RL19
        end
    end

    // Write gating
    always_comb begin
        if (dualWr) begin
            wrGate = ~wrEnFirstN & wrEnSecondOrLoad; // RL9
        end else begin
            wrGate = ~wrEnFirstN; // RL6
        end
    end

    assign wrAccept = wrGate & fullFlagN; // RL10 RL8
    assign next_wrPtr = wrPtr + dcsf_ptr_t'(wrAccept);

    // Write pointer, binary and Gray
    always_ff @(posedge core_clk) begin
        if (ce) begin
            if (fifoRst) begin
                wrPtr <= '0; // RL1
                wrGray <= '0;
            end else begin
                wrPtr <= next_wrPtr; // RL7
                wrGray <= bin2gray(next_wrPtr); // RL24
            end
        end
    end

    // Storage write, data held outside accepted cycles
    always_ff @(posedge core_clk) begin
        if (ce && !fifoRst && wrAccept) begin
            mem[wrPtr[AW-1:0]] <= wrDataIn; // RL5 RL7 RL8
        end
    end

    // Read pointer into the write side
    always_ff @(posedge core_clk) begin
        if (ce) begin
            if (fifoRst) begin
                rdGraySync1 <= '0;
                rdGraySync2 <= '0;
            end else begin
                rdGraySync1 <= rdGray; // RL24
                rdGraySync2 <= rdGraySync1; // RL13
            end
        end
    end

    assign wrLevel = next_wrPtr - gray2bin(rdGraySync2);

    // Write-side flags
    always_ff @(posedge core_clk) begin
        if (ce) begin
            if (fifoRst) begin
                fullFlagN <= 1'b1; // RL3
                almostFullFlagN <= 1'b1; // RL3
            end else begin
                fullFlagN <= (wrLevel != DEPTH_CNT); // RL10 RL11 RL12
                almostFullFlagN <= ~reachesFull(wrLevel, fullOfs); // RL21 RL12
            end
        end
    end

    // Read gating
    assign rdGate = ~rdEnAN & ~rdEnBN; // RL14 RL15
    assign rdAccept = rdGate & emptyFlagN; // RL16
    assign next_rdPtr = rdPtr + dcsf_ptr_t'(rdAccept);

    // Read pointer, binary and Gray
    always_ff @(posedge core_clk) begin
        if (ce) begin
            if (fifoRst) begin
                rdPtr <= '0; // RL1
                rdGray <= '0;
            end else begin
                rdPtr <= next_rdPtr;
                rdGray <= bin2gray(next_rdPtr); // RL24
            end
        end
    end

    // Output register
    always_ff @(posedge core_clk) begin
        if (ce) begin
            if (fifoRst) begin
                rdDataOut <= '0; // RL4
            end else if (rdAccept) begin
                rdDataOut <= mem[rdPtr[AW-1:0]]; // RL14 RL5
            end
        end
    end

    assign rdDataOe = ~outEnN; // RL20

    // Write pointer into the read side
    always_ff @(posedge core_clk) begin
        if (ce) begin
            if (fifoRst) begin
                wrGraySync1 <= '0;
                wrGraySync2 <= '0;
            end else begin
                wrGraySync1 <= wrGray; // RL24
                wrGraySync2 <= wrGraySync1; // RL13
            end
        end
    end

    assign rdLevel = gray2bin(wrGraySync2) - next_rdPtr;

    // Read-side flags
    always_ff @(posedge core_clk) begin
        if (ce) begin
            if (fifoRst) begin
                emptyFlagN <= 1'b0; // RL3
                almostEmptyFlagN <= 1'b0; // RL3
            end else begin
                emptyFlagN <= (rdLevel != '0); // RL16 RL17 RL18
                almostEmptyFlagN <= (OFS_W'(rdLevel) > emptyOfs); // RL22 RL18
            end
        end
    end

    assign flags = '{dualWr: dualWr, almostEmptyN: almostEmptyFlagN, emptyN: emptyFlagN,
                     almostFullN: almostFullFlagN, fullN: fullFlagN};

    // APB phases
    assign apbSetup = apbReq.psel & ~apbReq.penable;
    assign apbAccess = apbReq.psel & apbReq.penable;
    assign apbWrite = apbAccess & apbReq.pwrite & ce & addrHit;
    assign pready = apbAccess & ce;
    assign pslverr = apbAccess & ce & errReg;

    always_comb begin
        addrHit = 1'b1;
        rdMux = PRDATA_RST;
        unique case (apbReq.paddr)
            REG_STATUS: begin
                rdMux[ST_FLAGS_LSB +: ST_FLAGS_W] = flags;
                rdMux[ST_OVERRUN_BIT] = overrun;
                rdMux[ST_UNDERRUN_BIT] = underrun;
            end
            REG_EMPTY_OFS: rdMux = 32'(emptyOfs);
            REG_FULL_OFS: rdMux = 32'(fullOfs);
            REG_WR_LEVEL: rdMux = widen(wrPtr - gray2bin(rdGraySync2));
            REG_RD_LEVEL: rdMux = widen(gray2bin(wrGraySync2) - rdPtr);
            REG_CTRL: rdMux = PRDATA_RST;
            default: addrHit = 1'b0;
        endcase
    end

    // Read data and error captured in the setup cycle
    always_ff @(posedge core_clk) begin
        if (ce) begin
            if (rst) begin
                prdata <= PRDATA_RST;
                errReg <= 1'b0;
            end else if (apbSetup) begin
                prdata <= rdMux;
                errReg <= ~addrHit;
            end
        end
    end

    // Flag offsets
    always_ff @(posedge core_clk) begin
        if (ce) begin
            if (devRst) begin
                emptyOfs <= EMPTY_OFS_RST; // RL4
                fullOfs <= FULL_OFS_RST; // RL4
            end else if (apbWrite && apbReq.paddr == REG_EMPTY_OFS) begin
                emptyOfs <= apbReq.pwdata[OFS_W-1:0];
            end else if (apbWrite && apbReq.paddr == REG_FULL_OFS) begin
                fullOfs <= apbReq.pwdata[OFS_W-1:0];
            end
        end
    end

    // Flush pulse for one cycle
    always_ff @(posedge core_clk) begin
        if (ce) begin
            if (devRst) begin
                flushReq <= 1'b0;
            end else begin
                flushReq <= apbWrite && apbReq.paddr == REG_CTRL && apbReq.pwdata[CTRL_FLUSH_BIT];
            end
        end
    end

    // Refused-access sticky bits, set wins over write-one-to-clear
    always_ff @(posedge core_clk) begin
        if (ce) begin
            if (devRst) begin
                overrun <= 1'b0;
                underrun <= 1'b0;
            end else begin
                if (wrGate && !fullFlagN) begin
                    overrun <= 1'b1;
                end else if (apbWrite && apbReq.paddr == REG_STATUS && apbReq.pwdata[ST_OVERRUN_BIT]) begin
                    overrun <= 1'b0;
                end
                if (rdGate && !emptyFlagN) begin
                    underrun <= 1'b1;
                end else if (apbWrite && apbReq.paddr == REG_STATUS && apbReq.pwdata[ST_UNDERRUN_BIT]) begin
                    underrun <= 1'b0;
                end
            end
        end
    end

endmodule // dcsf_core

`default_nettype wire

/* test/dcsf_properties.sv */
/* Checker of the buffer core pins and flags.
   Assumes a bind onto dcsf_core, one clock. */
`default_nettype none
module dcsf_properties
    import dcsf_pkg::*;
#(parameter int DW = DATA_W) (
    // Clock, reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // Pins
    input wire logic resetNIn,
    input wire logic wrEnFirstN,
    input wire logic rdEnAN,
    input wire logic rdEnBN,
    input wire logic outEnN,
    input wire logic [DW-1:0] rdDataOut,
    input wire logic rdDataOe,
    // Flags
    input wire logic fullFlagN,
    input wire logic almostFullFlagN,
    input wire logic emptyFlagN,
    input wire logic almostEmptyFlagN
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wrAge;
    logic [3:0] rdAge;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Cycles since the last write or read request
    always_ff @(posedge core_clk) begin
        if (rst || !wrEnFirstN) wrAge <= 4'h0;
        else if (wrAge != 4'hF) wrAge <= wrAge + 4'h1;
    end
    always_ff @(posedge core_clk) begin
        if (rst || (!rdEnAN && !rdEnBN)) rdAge <= 4'h0;
        else if (rdAge != 4'hF) rdAge <= rdAge + 4'h1;
    end
    sequence s_held_out;
        (rdEnAN || rdEnBN) && resetNIn;
    endsequence
    sequence s_dry_out;
        !emptyFlagN && resetNIn;
    endsequence
    a_pin_reset: assert property (!resetNIn && ce |=> fullFlagN && almostFullFlagN
        && !emptyFlagN && !almostEmptyFlagN && rdDataOut == '0) else $error("reset state");
    a_oe_follow: assert property (rdDataOe == !outEnN) else $error("output enable");
    a_read_hold: assert property (s_held_out |=> $stable(rdDataOut)) else $error("held");
    a_empty_hold: assert property (s_dry_out |=> $stable(rdDataOut)) else $error("underflow");
    a_full_entry: assert property ($fell(fullFlagN) |-> !$past(wrEnFirstN)) else $error("full");
    a_empty_exit: assert property ($rose(emptyFlagN) |-> wrAge <= 4'h6) else $error("empty");
    a_full_exit: assert property ($rose(fullFlagN) && $past(resetNIn) |-> rdAge <= 4'h6)
        else $error("full release");
    a_full_nest: assert property (!fullFlagN |-> !almostFullFlagN) else $error("almost full");
    a_empty_nest: assert property (!emptyFlagN |-> !almostEmptyFlagN) else $error("almost empty");
endmodule // dcsf_properties
bind dcsf_core dcsf_properties #(.DW(DW)) dcsf_properties_inst (.core_clk(core_clk), .rst(rst),
    .ce(ce), .resetNIn(resetNIn), .wrEnFirstN(wrEnFirstN), .rdEnAN(rdEnAN), .rdEnBN(rdEnBN),
    .outEnN(outEnN), .rdDataOut(rdDataOut), .rdDataOe(rdDataOe), .fullFlagN(fullFlagN),
    .almostFullFlagN(almostFullFlagN), .emptyFlagN(emptyFlagN), .almostEmptyFlagN(almostEmptyFlagN));
`default_nettype wire

/* test/dcsf_stream_partner.sv */
/* Producer and consumer logic on the buffer pins.
   Assumes the bench steers it and resets it with rst. */
`default_nettype none
module dcsf_stream_partner
    import dcsf_pkg::*;
(
    // Clock, reset
    input wire logic core_clk,
    input wire logic rst,
    // Steering
    input wire logic [15:0] wrLimit,
    input wire logic wrOpen,
    input wire logic rdGo,
    input wire logic rdSlow,
    // Device side
    input wire logic fullFlagN,
    output logic wrEnFirstN,
    output logic [DATA_W-1:0] wrDataIn,
    output logic rdEnAN,
    output logic rdEnBN,
    output logic [15:0] wrCnt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] rdPhase;
    // Keeps pushing while full, as real logic may
    assign wrEnFirstN = rst || (wrCnt >= wrLimit);
    // Idle bus shows the inverted last word
    assign wrDataIn = rst ? 9'h000 : (wrEnFirstN ? ~(wrCnt[8:0] - 9'h001) : wrCnt[8:0]);
    // Slow mode lifts one or both enables three cycles in four
    assign rdEnAN = !rdGo || (rdSlow && rdPhase[0]);
    assign rdEnBN = !rdGo || (rdSlow && rdPhase[1]);
    always_ff @(posedge core_clk) begin
        if (rst) wrCnt <= 16'h0000;
        else if (!wrEnFirstN && fullFlagN && wrOpen) wrCnt <= wrCnt + 16'h0001;
    end
    always_ff @(posedge core_clk) begin
        if (rst) rdPhase <= 2'h0;
        else rdPhase <= rdPhase + 2'h1;
    end
endmodule // dcsf_stream_partner
`default_nettype wire

/* test/testbench.sv */
/* Bench: pin streams through the partner, registers over APB.
   Assumes the partner and the bound checker are compiled first. */
`default_nettype none
module testbench
    import dcsf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int D = 64;
    logic core_clk, rst, ce, resetNIn, wrEnFirstN, wrEnSecondOrLoad, rdEnAN, rdEnBN, outEnN;
    logic rdDataOe, fullFlagN, almostFullFlagN, emptyFlagN, almostEmptyFlagN, pready, pslverr;
    logic [DATA_W-1:0] wrDataIn, rdDataOut;
    logic [31:0] prdata;
    dcsf_apb_req_t apbReq;
    logic [15:0] wrLimit, wrCnt, rdExp, base;
    logic rdGo, rdSlow, dual, taken;
    int errors = 0, comparisons = 0, cyc = 0;
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    dcsf_core #(.DEPTH(D)) dcsf_core_inst (.core_clk(core_clk), .rst(rst), .ce(ce),
        .resetNIn(resetNIn), .wrEnFirstN(wrEnFirstN), .wrEnSecondOrLoad(wrEnSecondOrLoad),
        .rdEnAN(rdEnAN), .rdEnBN(rdEnBN), .outEnN(outEnN), .wrDataIn(wrDataIn), .rdDataOut(rdDataOut),
        .rdDataOe(rdDataOe), .fullFlagN(fullFlagN), .almostFullFlagN(almostFullFlagN),
        .emptyFlagN(emptyFlagN), .almostEmptyFlagN(almostEmptyFlagN), .apbReq(apbReq),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    dcsf_stream_partner dcsf_stream_partner_inst (.core_clk(core_clk), .rst(rst), .wrLimit(wrLimit),
        .wrOpen(wrEnSecondOrLoad | ~dual), .rdGo(rdGo), .rdSlow(rdSlow), .fullFlagN(fullFlagN),
        .wrEnFirstN(wrEnFirstN), .wrDataIn(wrDataIn), .rdEnAN(rdEnAN), .rdEnBN(rdEnBN), .wrCnt(wrCnt));
    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %0h seen %0h", w, e, g);
        end
    endtask
    task automatic flags(input logic [3:0] e);
        chk("flags", {28'h0, e}, {28'h0, fullFlagN, almostFullFlagN, emptyFlagN, almostEmptyFlagN});
    endtask
    task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d, input logic e);
        apbReq <= '{1'b1, 1'b0, wr, a, d};
        @(posedge core_clk);
        apbReq.penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        if (!wr) chk("prdata", d, prdata);
        chk("pslverr", {31'h0, e}, {31'h0, pslverr});
        apbReq <= '0;
        @(posedge core_clk);
    endtask
    task automatic fill(input int n);
        wrLimit <= base + 16'(n);
        @(posedge core_clk);
        while (wrCnt !== wrLimit) @(posedge core_clk);
        repeat (6) @(posedge core_clk);
    endtask
    task automatic drain;
        while (emptyFlagN !== 1'b0) @(posedge core_clk);
        repeat (8) @(posedge core_clk);
    endtask
    task automatic pinReset;
        resetNIn <= 1'b0;
        repeat (2) @(posedge core_clk);
        resetNIn <= 1'b1;
        @(posedge core_clk);
    endtask
    task automatic summarize;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Read word checker: one word per accepted read, in write order
    always @(posedge core_clk) begin
        taken <= !rdEnAN && !rdEnBN && emptyFlagN && resetNIn && !rst;
        if (rst || !resetNIn) rdExp <= wrCnt;
        else if (taken) begin
            chk("rdata", {23'h0, rdExp[8:0]}, {23'h0, rdDataOut});
            rdExp <= rdExp + 16'h0001;
        end
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            summarize();
        end
    end
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        resetNIn = 1'b1;
        wrEnSecondOrLoad = 1'b0;
        outEnN = 1'b0;
        apbReq = '0;
        wrLimit = 16'h0000;
        base = 16'h0000;
        rdGo = 1'b0;
        rdSlow = 1'b0;
        dual = 1'b0;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        flags(4'b1100);
        chk("rdata", 32'h0, {23'h0, rdDataOut});
        apb(1'b0, REG_STATUS, {27'h0, FLAGS_RST}, 1'b0);
        apb(1'b0, REG_FULL_OFS, {18'h0, FULL_OFS_RST}, 1'b0);
        apb(1'b0, 8'h18, 32'h0, 1'b1);
        fill(7);
        flags(4'b1110);
        fill(8);
        flags(4'b1111);
        fill(D - 8);
        flags(4'b1111);
        fill(D - 7);
        flags(4'b1011);
        wrLimit <= 16'(D + 3);
        repeat (12) @(posedge core_clk);
        flags(4'b0011);
        apb(1'b0, REG_WR_LEVEL, D, 1'b0);
        apb(1'b0, REG_STATUS, 32'h0000_010C, 1'b0);
        wrLimit <= wrCnt;
        apb(1'b1, REG_STATUS, 32'h0000_0100, 1'b0);
        apb(1'b0, REG_STATUS, 32'h0000_000C, 1'b0);
        rdGo <= 1'b1;
        rdSlow <= 1'b1;
        repeat (16) @(posedge core_clk);
        flags(4'b1011);
        drain();
        flags(4'b1100);
        chk("reads", {16'h0, rdExp}, {16'h0, wrCnt});
        rdSlow <= 1'b0;
        fill(D + 40);
        drain();
        chk("reads", {16'h0, rdExp}, {16'h0, wrCnt});
        rdGo <= 1'b0;
        dual <= 1'b1;
        wrEnSecondOrLoad <= 1'b1;
        base <= wrCnt;
        pinReset();
        apb(1'b0, REG_STATUS, 32'h13, 1'b0);
        apb(1'b1, REG_EMPTY_OFS, 32'h0000_0002, 1'b0);
        apb(1'b0, REG_EMPTY_OFS, 32'h0000_0002, 1'b0);
        wrEnSecondOrLoad <= 1'b0;
        wrLimit <= base + 16'h0004;
        repeat (10) @(posedge core_clk);
        flags(4'b1100);
        wrEnSecondOrLoad <= 1'b1;
        fill(4);
        flags(4'b1111);
        // Frozen clock enable: pin reset must not act
        ce <= 1'b0;
        pinReset();
        flags(4'b1111);
        ce <= 1'b1;
        // Software flush empties the buffer
        apb(1'b1, REG_CTRL, 32'h0000_0001, 1'b0);
        repeat (2) @(posedge core_clk);
        flags(4'b1100);
        pinReset();
        flags(4'b1100);
        apb(1'b0, REG_RD_LEVEL, 32'h0, 1'b0);
        apb(1'b0, REG_EMPTY_OFS, 32'h0000_0007, 1'b0);
        outEnN <= 1'b1;
        @(posedge core_clk);
        chk("oe", 32'h0, {31'h0, rdDataOe});
        summarize();
    end
endmodule // testbench
`default_nettype wire
